// >>> verilog/iftr_pkg.sv
// Constants for the instruction fetch address trap block.
`default_nettype none
package iftr_pkg;
  // Register indices; the bus byte address is four times the index.
  localparam logic [7:0] ADDR_CONTROL = 8'h34;
  localparam logic [7:0] ADDR_CODE    = 8'h35;
  localparam logic [7:0] ADDR_STATUS  = 8'h38;
  localparam logic [7:0] ADDR_AREA    = 8'h3c;
  localparam int RAM_SEL_BIT    = 5;
  localparam int ACT_SEL_BIT    = 4;
  localparam int GUARD_EN_BIT   = 3;
  localparam int GUARD_PER_LSB  = 1;
  localparam int GUARD_ACT_BIT  = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h39;
  localparam logic [7:0] CODE_ARM     = 8'hd2;
  localparam logic [7:0] CODE_CLEAR   = 8'h4e;
  localparam logic [7:0] CODE_DISABLE = 8'hb1;
  localparam int FC_HZ          = 16000000;
  localparam int CLK_HZ         = 25000000;
  localparam int RESET_FC_PERIODS = 24;
  localparam int RESET_CYCLES_RAW =
    (RESET_FC_PERIODS * (CLK_HZ / 1000)) / (FC_HZ / 1000);
  localparam int RESET_CYCLES =
    (RESET_CYCLES_RAW < 1) ? 1 : RESET_CYCLES_RAW;
  localparam logic [15:0] SFR_BASE_RESET = 16'h0000;
  localparam logic [15:0] SFR_LIMIT_RESET = 16'h003f;
  localparam logic [15:0] DBR_BASE_RESET = 16'h0f80;
  localparam logic [15:0] DBR_LIMIT_RESET = 16'h0fff;
  localparam logic [15:0] RAM_BASE_RESET = 16'h0040;
  localparam logic [15:0] RAM_LIMIT_RESET = 16'h083f;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    TRAP_IDLE  = 2'b00,
    TRAP_RESET = 2'b01,
    TRAP_HOLD  = 2'b11
  } iftr_state_t;
endpackage : iftr_pkg
`default_nettype wire

// >>> verilog/iftr_area_match.sv
// Fetch address classifier for the three trapping areas.
`default_nettype none
module iftr_area_match
  import iftr_pkg::*;
(
  input  wire logic [15:0] addr,
  input  wire logic        ram_armed,
  output logic             hit
);
  function automatic logic in_range(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  wire sfr_hit = in_range(addr, SFR_BASE_RESET, SFR_LIMIT_RESET);
  wire dbr_hit = in_range(addr, DBR_BASE_RESET, DBR_LIMIT_RESET);
  wire ram_hit = in_range(addr, RAM_BASE_RESET, RAM_LIMIT_RESET);

  assign hit = sfr_hit || dbr_hit || (ram_armed && ram_hit);
endmodule : iftr_area_match
`default_nettype wire

// >>> verilog/iftr_reset_timer.sv
// Stretches a trap reset request to a fixed length.
`default_nettype none
module iftr_reset_timer
  import iftr_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic start,
  output logic      busy
);
  logic [7:0] count_q;
  logic [7:0] count_d;

  // The request stands one cycle longer than the count runs, since the
  // state machine leaves its reset state only after busy has dropped.
  assign count_d = start ? 8'(RESET_CYCLES - 1)
                 : (count_q != 8'h00) ? count_q - 8'h01 : 8'h00;
  assign busy = (count_q != 8'h00);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_q <= 8'h00;
    else
      count_q <= count_d;
  end
endmodule : iftr_reset_timer
`default_nettype wire

// >>> verilog/iftr_top.sv
// Instruction fetch address trap with its AXI4-Lite register slave.
`default_nettype none
module iftr_top
  import iftr_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [15:0] fetch_addr,
  input  wire logic        fetch_opcode,
  input  wire logic        low_speed_mode_one,
  input  wire logic        nmi_return_instruction,
  output logic             fetch_trap_interrupt,
  output logic             trap_reset_request,
  output logic             fast_osc_restart,
  output logic             guard_counter_clear,
  output logic             guard_disable,
  output logic             guard_enable_bit,
  output logic [1:0]       guard_period_select,
  output logic             guard_action_select
);

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: address and data are latched in any order.
  logic       aw_have_q;
  logic       aw_have_d;
  logic [7:0] aw_addr_q;
  logic [7:0] aw_addr_d;
  logic       w_have_q;
  logic       w_have_d;
  logic [7:0] w_data_q;
  logic [7:0] w_data_d;
  logic       w_lane_q;
  logic       w_lane_d;
  logic       bvalid_q;
  logic       bvalid_d;
  logic [1:0] bresp_q;
  logic [1:0] bresp_d;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  wire wr_go   = aw_have_q && w_have_q && !bvalid_q;

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  assign aw_have_d = wr_go ? 1'b0 : (aw_have_q || aw_take);
  assign aw_addr_d = aw_take ? s_axi_awaddr : aw_addr_q;
  assign w_have_d  = wr_go ? 1'b0 : (w_have_q || w_take);
  assign w_data_d  = w_take ? s_axi_wdata[7:0] : w_data_q;
  assign w_lane_d  = w_take ? s_axi_wstrb[0] : w_lane_q;

  // Each register owns one 32-bit word at four times its index, so the
  // control word and the code register never alias on the bus.
  function automatic logic reg_hit(input logic [7:0] byte_addr,
                                   input logic [7:0] index);
    reg_hit = (byte_addr[7:2] == index[5:0]);
  endfunction : reg_hit

  // Only byte lane 0 carries register bits; a write without it still
  // completes with OKAY but changes nothing.
  wire wr_ctrl = wr_go && w_lane_q && reg_hit(aw_addr_q, ADDR_CONTROL);
  wire wr_code = wr_go && w_lane_q && reg_hit(aw_addr_q, ADDR_CODE);
  wire wr_mapped = reg_hit(aw_addr_q, ADDR_CONTROL)
                   || reg_hit(aw_addr_q, ADDR_CODE)
                   || reg_hit(aw_addr_q, ADDR_STATUS)
                   || reg_hit(aw_addr_q, ADDR_AREA);

  assign bvalid_d = wr_go ? 1'b1 : (bvalid_q && !s_axi_bready);
  assign bresp_d  = wr_go ? (wr_mapped ? RESP_OKAY : RESP_SLVERR)
                          : bresp_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_have_q  <= 1'b0;
      w_data_q  <= 8'h00;
      w_lane_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end
    else
    begin
      aw_have_q <= aw_have_d;
      aw_addr_q <= aw_addr_d;
      w_have_q  <= w_have_d;
      w_data_q  <= w_data_d;
      w_lane_q  <= w_lane_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared control word and the code register.
  logic [7:0] control_q;
  logic [7:0] control_d;
  logic       ram_armed_q;
  logic       ram_armed_d;
  logic       guard_off_q;
  logic       guard_off_d;

  wire [7:0] code = w_data_q;

  assign control_d = wr_ctrl ? w_data_q : control_q;

  // RAM trap gate
  // The select bit written earlier reaches the classifier only here, so
  // a stray control write cannot open or close the RAM area by itself.
  wire arm_go = wr_code && (code == CODE_ARM);
  assign ram_armed_d = arm_go ? control_q[RAM_SEL_BIT] : ram_armed_q;

  assign guard_counter_clear = wr_code && (code == CODE_CLEAR);
  assign guard_off_d = (wr_code && code == CODE_DISABLE
                        && !control_q[GUARD_EN_BIT]) ? 1'b1
                     : (control_q[GUARD_EN_BIT] ? 1'b0 : guard_off_q);
  assign guard_disable       = guard_off_q;
  assign guard_enable_bit    = control_q[GUARD_EN_BIT];
  assign guard_period_select = control_q[GUARD_PER_LSB +: 2];
  assign guard_action_select = control_q[GUARD_ACT_BIT];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      control_q   <= CONTROL_RESET;
      ram_armed_q <= 1'b1;
      guard_off_q <= 1'b0;
    end
    else
    begin
      control_q   <= control_d;
      ram_armed_q <= ram_armed_d;
      guard_off_q <= guard_off_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Trap detection and action.
  logic        area_hit;
  logic        timer_busy;
  iftr_state_t state_q;
  iftr_state_t state_d;
  logic        irq_q;
  logic        irq_d;
  logic [7:0]  nest_q;
  logic [7:0]  nest_d;
  logic [15:0] last_addr_q;
  logic [15:0] last_addr_d;

  iftr_area_match u_match
  (
    .addr      (fetch_addr),
    .ram_armed (ram_armed_q),
    .hit       (area_hit)
  );

  // Fetches are ignored while a reset is stretched and in the cycle
  // after it, so a stale fetch cannot cut the restart short.
  // opcode fetch only
  wire trap = fetch_opcode && area_hit && (state_q == TRAP_IDLE);
  wire act_reset = control_q[ACT_SEL_BIT];
  wire reset_start = trap && act_reset;

  iftr_reset_timer u_timer
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (reset_start),
    .busy    (timer_busy)
  );

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      TRAP_IDLE:
        if (reset_start)
          state_d = TRAP_RESET;
      TRAP_RESET:
        if (!timer_busy)
          state_d = TRAP_HOLD;
      TRAP_HOLD:
        state_d = TRAP_IDLE;
      default:
        state_d = TRAP_IDLE;
    endcase
  end

  // new trap raised unless reset action selected; CPU nests
  assign irq_d = trap && !act_reset;
  // Nesting depth for status; it saturates so that a runaway loop of
  // traps cannot wrap it back to zero.
  assign nest_d = (irq_d && !nmi_return_instruction && nest_q != 8'hff)
                  ? nest_q + 8'h01
                : (!irq_d && nmi_return_instruction && nest_q != 8'h00)
                  ? nest_q - 8'h01 : nest_q;
  assign last_addr_d = trap ? fetch_addr : last_addr_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q     <= TRAP_IDLE;
      irq_q       <= 1'b0;
      nest_q      <= 8'h00;
      last_addr_q <= 16'h0000;
    end
    else
    begin
      state_q     <= state_d;
      irq_q       <= irq_d;
      nest_q      <= nest_d;
      last_addr_q <= last_addr_d;
    end
  end

  assign fetch_trap_interrupt = irq_q;
  // bounded reset length
  // It stands RESET_CYCLES cycles, which stays within 24 fast periods.
  assign trap_reset_request   = (state_q == TRAP_RESET);
  assign fast_osc_restart = trap_reset_request && low_speed_mode_one;

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel: the shared word is write-only and reads zero.
  logic        rvalid_q;
  logic        rvalid_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [1:0]  rresp_q;
  logic [1:0]  rresp_d;

  wire ar_take = s_axi_arvalid && s_axi_arready;
  // The control and code words are write-only and read back as zero.
  wire rd_ctrl = reg_hit(s_axi_araddr, ADDR_CONTROL)
                 || reg_hit(s_axi_araddr, ADDR_CODE);
  wire rd_stat = reg_hit(s_axi_araddr, ADDR_STATUS);
  wire rd_area = reg_hit(s_axi_araddr, ADDR_AREA);
  wire [31:0] stat_word = {nest_q, 20'h00000, ram_armed_q,
                           guard_off_q, trap_reset_request, irq_q};
  wire [31:0] rd_word = rd_stat ? stat_word
                      : rd_area ? {16'h0000, last_addr_q} : 32'h00000000;

  assign s_axi_arready = !rvalid_q;
  assign rvalid_d = ar_take ? 1'b1 : (rvalid_q && !s_axi_rready);
  assign rdata_d  = ar_take ? rd_word : rdata_q;
  assign rresp_d  = ar_take ? ((rd_ctrl || rd_stat || rd_area)
                               ? RESP_OKAY : RESP_SLVERR) : rresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= RESP_OKAY;
    end
    else
    begin
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
    end
  end

endmodule : iftr_top
`default_nettype wire

// >>> tb/iftr_top_asserts.sv
// Port checker for the instruction fetch address trap block.
`default_nettype none
module iftr_top_asserts
  import iftr_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_wdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [15:0] fetch_addr,
  input wire logic        fetch_opcode,
  input wire logic        low_speed_mode_one,
  input wire logic        fetch_trap_interrupt,
  input wire logic        trap_reset_request,
  input wire logic        fast_osc_restart,
  input wire logic        guard_counter_clear,
  input wire logic        guard_disable,
  input wire logic        guard_enable_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_q;
  // Counts how long the trap reset has been standing.
  always_ff @(posedge aclk)
    if (!aresetn || !trap_reset_request) cnt_q <= 8'h00;
    else cnt_q <= cnt_q + 8'h01;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_SFR_TRAP: assert property (fetch_opcode && fetch_addr <= 16'h003f
    && !trap_reset_request && !$past(trap_reset_request)
    |=> fetch_trap_interrupt || trap_reset_request) else $error("no trap");
  AST_DBR_TRAP: assert property (fetch_opcode && fetch_addr >= 16'h0f80
    && fetch_addr <= 16'h0fff && !trap_reset_request
    && !$past(trap_reset_request)
    |=> fetch_trap_interrupt || trap_reset_request) else $error("no trap");
  AST_IRQ_CAUSE: assert property (fetch_trap_interrupt
    |-> $past(fetch_opcode)) else $error("irq without fetch");
  AST_RST_CAUSE: assert property ($rose(trap_reset_request)
    |-> $past(fetch_opcode)) else $error("reset without fetch");
  AST_ONE_ACTION: assert property (!(fetch_trap_interrupt
    && trap_reset_request)) else $error("both actions");
  AST_RST_LEN: assert property ($fell(trap_reset_request)
    |-> cnt_q == RESET_CYCLES) else $error("reset length");
  AST_RST_MAX: assert property (trap_reset_request
    |-> cnt_q < RESET_CYCLES) else $error("reset too long");
  AST_OSC: assert property (fast_osc_restart == (trap_reset_request
    && low_speed_mode_one)) else $error("osc restart");
  AST_CLEAR: assert property (guard_counter_clear
    |-> s_axi_wdata == 8'h4e) else $error("clear code");
  AST_DISABLE: assert property ($rose(guard_disable)
    |-> !guard_enable_bit) else $error("disable while enabled");
  AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid");
  AST_RANS: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("rvalid");
  COV_IRQ: cover property (fetch_trap_interrupt ##1 fetch_trap_interrupt);
  COV_RST: cover property ($fell(trap_reset_request));
  COV_CLR: cover property (guard_counter_clear);
endmodule : iftr_top_asserts
bind iftr_top iftr_top_asserts u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_wdata(s_axi_wdata[7:0]), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .fetch_addr(fetch_addr),
  .fetch_opcode(fetch_opcode), .low_speed_mode_one(low_speed_mode_one),
  .fetch_trap_interrupt(fetch_trap_interrupt),
  .trap_reset_request(trap_reset_request),
  .fast_osc_restart(fast_osc_restart),
  .guard_counter_clear(guard_counter_clear),
  .guard_disable(guard_disable), .guard_enable_bit(guard_enable_bit));
`default_nettype wire

// >>> tb/iftr_cpu_model.sv
// Behavioural CPU fetch stream facing the trap block.
`default_nettype none
module iftr_cpu_model
(
  input  wire logic  aclk,
  output var logic [15:0] fetch_addr,
  output var logic   fetch_opcode,
  output var logic   nmi_return_instruction
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    fetch_addr = 16'h0000;
    fetch_opcode = 1'b0;
    nmi_return_instruction = 1'b0;
  end
  task fetch(input logic [15:0] a, input logic op, input int n);
    @(posedge aclk);
    fetch_addr <= a;
    fetch_opcode <= op;
    repeat (n) @(posedge aclk);
    fetch_opcode <= 1'b0;
    fetch_addr <= ~a;
  endtask : fetch
  task nmi_ret();
    @(posedge aclk);
    nmi_return_instruction <= 1'b1;
    @(posedge aclk);
    nmi_return_instruction <= 1'b0;
  endtask : nmi_ret
endmodule : iftr_cpu_model
`default_nettype wire

// >>> tb/iftr_top_bench.sv
// Self-checking bench for the instruction fetch address trap.
`default_nettype none
module iftr_top_bench
  import iftr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, slow = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  wire logic [15:0] fa;
  wire logic op, nmi, awready, wready, bvalid, arready, rvalid;
  wire logic irq, trst, osc, gclr, gdis, gen, gact;
  wire logic [1:0] bresp, rresp, gper;
  wire logic [31:0] rdata;
  int err_count = 0, checks = 0, n_irq = 0, n_rst = 0, n_osc = 0;
  int n_clr = 0, m_irq, m_rst, m_osc, m_clr;
  always #20 aclk = ~aclk;
  always @(posedge aclk)
  begin
    n_irq += irq;
    n_rst += trst;
    n_osc += osc;
    n_clr += gclr;
  end
  iftr_cpu_model cpu (.aclk(aclk), .fetch_addr(fa), .fetch_opcode(op),
    .nmi_return_instruction(nmi));
  iftr_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .fetch_addr(fa), .fetch_opcode(op),
    .low_speed_mode_one(slow), .nmi_return_instruction(nmi),
    .fetch_trap_interrupt(irq), .trap_reset_request(trst),
    .fast_osc_restart(osc), .guard_counter_clear(gclr),
    .guard_disable(gdis), .guard_enable_bit(gen),
    .guard_period_select(gper), .guard_action_select(gact));
  ////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task mark();
    m_irq = n_irq;
    m_rst = n_rst;
    m_osc = n_osc;
    m_clr = n_clr;
  endtask : mark
  task ev(input int i, input int r, input int o, input int c);
    repeat (3) @(posedge aclk);
    chk(n_irq - m_irq, i);
    chk(n_rst - m_rst, r);
    chk(n_osc - m_osc, o);
    chk(n_clr - m_clr, c);
    mark();
  endtask : ev
  // Register accesses take the register index; the byte address is four
  // times the index.
  task axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e);
    @(posedge aclk);
    awaddr <= {a[5:0], 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk(bresp, e);
  endtask : axw
  task axr(input logic [7:0] a, input logic [1:0] e,
           input logic [31:0] d);
    @(posedge aclk);
    araddr <= {a[5:0], 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk(rresp, e);
    chk(rdata, d);
  endtask : axr
  task hw_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    mark();
  endtask : hw_reset
  task tally_and_finish();
    $display("mismatches %0d of %0d checks", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6000) @(posedge aclk);
    err_count++;
    tally_and_finish();
  end
  initial
  begin
    hw_reset();
    chk({gen, gper, gact}, 4'b1001);
    slow <= 1'b1;
    cpu.fetch(16'h0010, 1'b1, 1);
    repeat (42) @(posedge aclk);
    ev(0, RESET_CYCLES, RESET_CYCLES, 0);
    slow <= 1'b0;
    hw_reset();
    axw(ADDR_CONTROL, 8'h08, RESP_OKAY);
    chk({gen, gper, gact}, 4'b1000);
    cpu.fetch(16'h0100, 1'b1, 1);
    ev(1, 0, 0, 0);
    axw(ADDR_CODE, CODE_ARM, RESP_OKAY);
    axw(ADDR_CONTROL, 8'h08, RESP_OKAY);
    cpu.fetch(16'h0100, 1'b1, 1);
    ev(0, 0, 0, 0);
    cpu.fetch(16'h0020, 1'b1, 2);
    ev(2, 0, 0, 0);
    cpu.fetch(16'h0f80, 1'b1, 1);
    cpu.fetch(16'h0fff, 1'b1, 1);
    cpu.fetch(16'h003f, 1'b1, 1);
    ev(3, 0, 0, 0);
    cpu.fetch(16'h0f7f, 1'b1, 1);
    cpu.fetch(16'h1000, 1'b1, 1);
    cpu.fetch(16'h0010, 1'b0, 2);
    cpu.nmi_ret();
    ev(0, 0, 0, 0);
    axw(ADDR_CODE, CODE_CLEAR, RESP_OKAY);
    axw(ADDR_CODE, 8'h55, RESP_OKAY);
    ev(0, 0, 0, 1);
    axw(ADDR_CONTROL, 8'h00, RESP_OKAY);
    axw(ADDR_CODE, CODE_DISABLE, RESP_OKAY);
    chk(gdis, 1'b1);
    axw(8'h20, 8'h00, RESP_SLVERR);
    axr(8'h20, RESP_SLVERR, 32'h00000000);
    axr(ADDR_CONTROL, RESP_OKAY, 32'h00000000);
    axr(ADDR_CODE, RESP_OKAY, 32'h00000000);
    axr(ADDR_STATUS, RESP_OKAY, 32'h05000004);
    axr(ADDR_AREA, RESP_OKAY, 32'h0000003f);
    tally_and_finish();
  end
endmodule : iftr_top_bench
`default_nettype wire
